/* add_instruction_decode_bench.sv */
/* Self-checking bench for aid_core: every opcode, corners, random.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module add_instruction_decode_bench;
	reg clk_in = 1'b0;
	reg rstn_in = 1'b0;
	reg start_in = 1'b0;
	reg flags_wr_in = 1'b0;
	reg [7:0] opcode_in = 8'h00;
	reg [7:0] dst_val_in = 8'h00;
	reg [7:0] src_val_in = 8'h00;
	reg [7:0] flags_data_in = 8'h00;
	wire busy_out, fetch_phase_out, done_out, illegal_out, result_wr_out;
	wire [2:0] dst_mode_out, src_mode_out;
	wire [7:0] result_out, flags_out;
	reg [7:0] fl = 8'h00;
	integer n_mismatch = 0;
	integer num_checks = 0;
	integer i, n, nf;
	aid_core uut (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start_in),
		.opcode_in(opcode_in), .dst_val_in(dst_val_in),
		.src_val_in(src_val_in), .flags_wr_in(flags_wr_in),
		.flags_data_in(flags_data_in), .busy_out(busy_out),
		.fetch_phase_out(fetch_phase_out), .dst_mode_out(dst_mode_out),
		.src_mode_out(src_mode_out), .done_out(done_out),
		.illegal_out(illegal_out), .result_wr_out(result_wr_out),
		.result_out(result_out), .flags_out(flags_out));
	// free-running clock
	always #5 clk_in = ~clk_in;
	// one comparison
	task chk(input [7:0] seen, input [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task wrap_up;
		$display("mismatches=%0d checks=%0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// expected sum over expected flag byte
	function [15:0] calc(input [7:0] op, d, s, f);
		reg [8:0] t;
		reg c;
		c = op[4] & f[7];
		t = d + s + c;
		calc = {t[7:0], t[8], t[7:0] == 8'h00, t[7],
			(d[7] == s[7]) && (t[7] != d[7]), 1'b0,
			(d[3:0] + s[3:0] + c) > 5'h0F, f[1:0]};
	endfunction
	// expected fetch plus execute cycles
	function [7:0] lat(input [7:0] op);
		lat = (op[3:0] < 4'h4 ? 8'h02 : op[3:0] < 4'h8 ? 8'h03 : 8'h04)
			+ (op[0] && op[3:0] < 4'h8 && op[3:0] > 4'h2 ? 8'h04 : 8'h03);
	endfunction
	// expected fetch cycles alone
	function [7:0] fch(input [7:0] op);
		fch = op[3:0] < 4'h4 ? 8'h02 : op[3:0] < 4'h8 ? 8'h03 : 8'h04;
	endfunction
	// expected dst and src addressing codes, dst in the upper field
	function [7:0] mds(input [7:0] op);
		case (op[3:0])
		4'h2: mds = 8'h00;
		4'h3: mds = 8'h01;
		4'h4: mds = 8'h12;
		4'h5: mds = 8'h13;
		4'h6: mds = 8'h14;
		4'h7: mds = 8'h1C;
		4'h8: mds = 8'h2D;
		4'h9: mds = 8'h2C;
		default: mds = 8'h3F;
		endcase
	endfunction
	// one instruction; a second start while busy must be ignored
	task run(input [7:0] op, d, s);
		reg bad;
		reg [15:0] e;
		bad = op[7:5] != 3'h0 || op[3:0] < 4'h2 || op[3:0] > 4'h9;
		e = calc(op, d, s, fl);
		start_in = 1'b1;
		opcode_in = op;
		dst_val_in = d;
		src_val_in = s;
		// start stays up over the next edge, where busy must refuse it;
		// lowered only once so a back-to-back start never rewrites it
		@(posedge clk_in);
		#1 n = 0;
		nf = (fetch_phase_out === 1'b1);
		while (done_out !== 1'b1 && n < 20) begin
			@(posedge clk_in);
			#1 n++;
			nf = nf + (fetch_phase_out === 1'b1);
			if (n == 1)
				start_in = 1'b0;
		end
		if (n == 20) begin
			n_mismatch++;
			wrap_up;
		end
		chk(n[7:0], bad ? 8'h00 : lat(op));
		chk(nf[7:0], bad ? 8'h00 : fch(op));
		chk({6'h00, illegal_out, result_wr_out}, {6'h00, bad, !bad});
		chk({7'h00, busy_out}, 8'h00);
		if (!bad)
			chk(result_out, e[15:8]);
		if (!bad)
			chk({2'h0, dst_mode_out, src_mode_out}, mds(op));
		if (!bad)
			fl = e[7:0];
		chk(flags_out, fl);
	endtask
	// main sequence
	initial begin
		void'($urandom(32'hFDC5694B));
		repeat (2) @(posedge clk_in);
		#1 rstn_in = 1'b1;
		// loaded carry must feed the carry sum
		flags_wr_in = 1'b1;
		flags_data_in = 8'hFF;
		@(posedge clk_in);
		#1 flags_wr_in = 1'b0;
		fl = 8'hFF;
		run(8'h12, 8'h00, 8'h00);
		// every opcode, wrap and overflow corners back to back
		for (i = 0; i < 16; i++)
			run({3'h0, i[3], 4'h2 + {1'b0, i[2:0]}}, i[0] ? 8'hFF : 8'h7F,
				8'h01);
		run(8'h0A, 8'h55, 8'h01);
		run(8'h11, 8'h55, 8'h01);
		run(8'hFF, 8'h55, 8'h01);
		repeat (60)
			run({3'h0, 1'($urandom), 4'h2 + 4'($urandom % 8)},
				8'($urandom), 8'($urandom));
		wrap_up;
	end
endmodule

/* aid_chk_sva.sv */
/* Checker for aid_core: latencies, fetch span, modes and flags.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module aid_chk #(
	parameter DATA_W = 8
) (
	// clock, reset and request
	input wire clk_in,
	input wire rstn_in,
	input wire start_in,
	input wire [7:0] opcode_in,
	input wire flags_wr_in,
	// design outputs
	input wire busy_out,
	input wire fetch_phase_out,
	input wire [2:0] dst_mode_out,
	input wire [2:0] src_mode_out,
	input wire done_out,
	input wire illegal_out,
	input wire result_wr_out,
	input wire [DATA_W-1:0] result_out,
	input wire [7:0] flags_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// accepted request, high nibble limited to sum forms
	wire acc = start_in && !busy_out && opcode_in[7:5] == 3'h0;
	AST_LAT_WR: assert property (
		acc && opcode_in[3:0] == 4'h2 |=> busy_out[*5] ##1 done_out)
		else $error("working pair latency wrong");
	AST_LAT_IND: assert property (
		acc && opcode_in[3:0] == 4'h5 |=> busy_out[*7] ##1 done_out)
		else $error("indirect latency wrong");
	AST_LAT_EXT: assert property (
		acc && opcode_in[3:0] == 4'h9 |=> busy_out[*7] ##1 done_out)
		else $error("extended latency wrong");
	AST_FETCH_EXT: assert property (
		acc && opcode_in[3:0] == 4'h8 |=> fetch_phase_out[*4]
		##1 !fetch_phase_out) else $error("extended fetch length wrong");
	AST_MODES: assert property (
		acc && opcode_in[3:0] == 4'h9 |=> dst_mode_out == 3'h5
		&& src_mode_out == 3'h4) else $error("extended modes wrong");
	AST_D_CLEAR: assert property (
		result_wr_out |-> !flags_out[3]) else $error("decimal flag set");
	AST_ZS: assert property (
		result_wr_out |-> flags_out[6] == (result_out == 0)
		&& flags_out[5] == result_out[DATA_W-1])
		else $error("zero or sign flag wrong");
	AST_HOLD: assert property (
		!result_wr_out && !$past(flags_wr_in) && $past(rstn_in)
		|-> $stable(flags_out)) else $error("flags moved");
	// main scenarios reached
	cover property (illegal_out);
	cover property (result_wr_out && flags_out[7]);
	cover property (acc && opcode_in == 8'h19);
endmodule
bind aid_core aid_chk #(.DATA_W(DATA_W)) u_chk (.clk_in(clk_in),
	.rstn_in(rstn_in), .start_in(start_in), .opcode_in(opcode_in),
	.flags_wr_in(flags_wr_in), .busy_out(busy_out),
	.fetch_phase_out(fetch_phase_out), .dst_mode_out(dst_mode_out),
	.src_mode_out(src_mode_out), .done_out(done_out),
	.illegal_out(illegal_out), .result_wr_out(result_wr_out),
	.result_out(result_out), .flags_out(flags_out));

/* aid_core.v */
/*
 * Decode and execute unit for the twelve addition opcodes and their
 * extended forms. Takes an opcode with its two operand values, walks
 * the fetch and execute phases for the documented cycle counts, then
 * hands back the sum, a write strobe and the updated flag byte.
 * Assumes the surrounding core fetches operands for the reported
 * addressing modes and writes the result to the destination itself.
 * All inputs come from logic on clk_in; none is synchronised.
 */
`timescale 1ns/1ps
`include "aid_defs.vh"

module aid_core #(
	parameter DATA_W = 8
) (
	// clock and reset
	input wire clk_in,
	input wire rstn_in,
	// instruction request
	input wire start_in,
	input wire [7:0] opcode_in,
	input wire [DATA_W-1:0] dst_val_in,
	input wire [DATA_W-1:0] src_val_in,
	// flag load from other instructions
	input wire flags_wr_in,
	input wire [7:0] flags_data_in,
	// decode report
	output wire busy_out,
	output wire fetch_phase_out,
	output wire [2:0] dst_mode_out,
	output wire [2:0] src_mode_out,
	// completion
	output wire done_out,
	output wire illegal_out,
	output wire result_wr_out,
	output wire [DATA_W-1:0] result_out,
	output wire [7:0] flags_out
);

	localparam ST_IDLE = 2'h0;
	localparam ST_FETCH = 2'h1;
	localparam ST_EXEC = 2'h2;

	// decode word: valid, carry, dst mode, src mode, fetch, exec
	function [13:0] aid_decode;
		input [7:0] op;
		reg carry_use;
		reg ok;
		reg [2:0] dm;
		reg [2:0] sm;
		reg [2:0] fc;
		reg [2:0] ec;
		begin
			carry_use = (op[7:4] == `AID_OP_HI_ADC);
			ok = (op[7:4] == `AID_OP_HI_SUM) ||
				(op[7:4] == `AID_OP_HI_ADC);
			dm = `AID_MODE_NONE;
			sm = `AID_MODE_NONE;
			fc = `AID_FETCH_WR;
			ec = `AID_EXEC_DIRECT;
			case (op[3:0])
			`AID_OP_LO_WR_WR: begin
				dm = `AID_MODE_WR;
				sm = `AID_MODE_WR;
			end
			`AID_OP_LO_WR_WRI: begin
				dm = `AID_MODE_WR;
				sm = `AID_MODE_WR_IND;
				ec = `AID_EXEC_INDIRECT;
			end
			`AID_OP_LO_FR_FR: begin
				dm = `AID_MODE_FR;
				sm = `AID_MODE_FR;
				fc = `AID_FETCH_FR;
			end
			`AID_OP_LO_FR_FRI: begin
				dm = `AID_MODE_FR;
				sm = `AID_MODE_FR_IND;
				fc = `AID_FETCH_FR;
				ec = `AID_EXEC_INDIRECT;
			end
			`AID_OP_LO_FR_IMM: begin
				dm = `AID_MODE_FR;
				sm = `AID_MODE_IMM;
				fc = `AID_FETCH_FR;
			end
			`AID_OP_LO_FRI_IMM: begin
				dm = `AID_MODE_FR_IND;
				sm = `AID_MODE_IMM;
				fc = `AID_FETCH_FR;
				ec = `AID_EXEC_INDIRECT;
			end
			`AID_OP_LO_EXT_EXT: begin
				dm = `AID_MODE_EXT;
				sm = `AID_MODE_EXT;
				fc = `AID_FETCH_EXT;
			end
			`AID_OP_LO_EXT_IMM: begin
				dm = `AID_MODE_EXT;
				sm = `AID_MODE_IMM;
				fc = `AID_FETCH_EXT;
			end
			default: begin
				ok = 1'b0;
			end
			endcase
			aid_decode = {ok, carry_use, dm, sm, fc, ec};
		end
	endfunction

	wire [13:0] dec_word;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [2:0] cnt_reg;
	reg [2:0] cnt_next;
	reg [2:0] exec_len_reg;
	reg use_carry_reg;
	reg carry_in_reg;
	reg [DATA_W-1:0] dst_reg;
	reg [DATA_W-1:0] src_reg;
	reg [2:0] dst_mode_reg;
	reg [2:0] src_mode_reg;
	reg busy_reg;
	reg fetch_phase_reg;
	reg done_reg;
	reg illegal_reg;
	reg result_wr_reg;
	reg [DATA_W-1:0] result_reg;
	reg [7:0] flags_reg;
	reg [DATA_W:0] sum_full;
	reg [4:0] half_sum;
	reg ovf;
	reg finish;

	assign dec_word = aid_decode(opcode_in);

	// sum and flag terms from the latched operands
	always @* begin
		sum_full = {1'b0, dst_reg} + {1'b0, src_reg} +
			{{DATA_W{1'b0}}, use_carry_reg & carry_in_reg};
		half_sum = {1'b0, dst_reg[3:0]} + {1'b0, src_reg[3:0]} +
			{4'h0, use_carry_reg & carry_in_reg};
		ovf = (dst_reg[DATA_W-1] == src_reg[DATA_W-1]) &&
			(sum_full[DATA_W-1] != dst_reg[DATA_W-1]);
	end

	// phase sequencing; counter holds cycles left minus one
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		finish = 1'b0;
		case (state_reg)
		ST_IDLE: begin
			if (start_in && dec_word[13]) begin
				state_next = ST_FETCH;
				cnt_next = dec_word[5:3] - 3'h1;
			end
		end
		ST_FETCH: begin
			if (cnt_reg == 3'h0) begin
				state_next = ST_EXEC;
				cnt_next = exec_len_reg - 3'h1;
			end else begin
				cnt_next = cnt_reg - 3'h1;
			end
		end
		ST_EXEC: begin
			if (cnt_reg == 3'h0) begin
				state_next = ST_IDLE;
				finish = 1'b1;
			end else begin
				cnt_next = cnt_reg - 3'h1;
			end
		end
		default: begin
			state_next = ST_IDLE;
			cnt_next = 3'h0;
		end
		endcase
	end

	// state, counter and phase outputs
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 3'h0;
			busy_reg <= 1'b0;
			fetch_phase_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			busy_reg <= (state_next != ST_IDLE);
			fetch_phase_reg <= (state_next == ST_FETCH);
		end
	end

	// operand and decode capture on an accepted start
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			exec_len_reg <= `AID_EXEC_DIRECT;
			use_carry_reg <= 1'b0;
			carry_in_reg <= 1'b0;
			dst_reg <= {DATA_W{1'b0}};
			src_reg <= {DATA_W{1'b0}};
			dst_mode_reg <= `AID_MODE_NONE;
			src_mode_reg <= `AID_MODE_NONE;
		end else if (state_reg == ST_IDLE && start_in &&
			dec_word[13]) begin
			exec_len_reg <= dec_word[2:0];
			// carry only for the carry opcodes
			use_carry_reg <= dec_word[12];
			carry_in_reg <= flags_reg[`AID_FLAG_C];
			dst_reg <= dst_val_in;
			src_reg <= src_val_in;
			dst_mode_reg <= dec_word[11:9];
			src_mode_reg <= dec_word[8:6];
		end
	end

	// completion strobes and result
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			done_reg <= 1'b0;
			illegal_reg <= 1'b0;
			result_wr_reg <= 1'b0;
			result_reg <= {DATA_W{1'b0}};
		end else begin
			// unknown opcode answers at once, no write
			illegal_reg <= (state_reg == ST_IDLE) && start_in &&
				!dec_word[13];
			done_reg <= finish || ((state_reg == ST_IDLE) &&
				start_in && !dec_word[13]);
			result_wr_reg <= finish;
			if (finish)
				result_reg <= sum_full[DATA_W-1:0];
		end
	end

	// flag byte; instruction update wins over a load
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			flags_reg <= `AID_FLAGS_RESET;
		end else if (finish) begin
			flags_reg[`AID_FLAG_C] <= sum_full[DATA_W];
			flags_reg[`AID_FLAG_Z] <= (sum_full[DATA_W-1:0] ==
				{DATA_W{1'b0}});
			flags_reg[`AID_FLAG_S] <= sum_full[DATA_W-1];
			flags_reg[`AID_FLAG_V] <= ovf;
			flags_reg[`AID_FLAG_D] <= 1'b0;
			flags_reg[`AID_FLAG_H] <= half_sum[4];
		end else if (flags_wr_in) begin
			flags_reg <= flags_data_in;
		end
	end

	// outputs straight from flip-flops
	assign busy_out = busy_reg;
	assign fetch_phase_out = fetch_phase_reg;
	assign dst_mode_out = dst_mode_reg;
	assign src_mode_out = src_mode_reg;
	assign done_out = done_reg;
	assign illegal_out = illegal_reg;
	assign result_wr_out = result_wr_reg;
	assign result_out = result_reg;
	assign flags_out = flags_reg;

endmodule

/* aid_defs.vh */
/*
 * Constants for the addition decode and execute block: opcodes,
 * operand addressing codes, fetch and execute cycle counts, and flag
 * bit positions.
 * Assumes one plain include per design file; definitions only.
 */
// Operation
// - carry sum, opcodes 12..17, adds carry
// - plain sum, opcodes 02..07, no carry
// - extended forms: 18, 19, 08, 09
// - C Z S V H from result, D cleared
// - fetch takes 2, 3 or 4 cycles
// - execute takes 3, or 4 when indirect
`ifndef AID_DEFS_VH
`define AID_DEFS_VH

// opcodes, high nibble picks carry, low nibble picks addressing
`define AID_OP_SUM_RR 8'h02
`define AID_OP_SUM_EXT_IMM 8'h09
`define AID_OP_ADC_RR 8'h12
`define AID_OP_ADC_EXT_IMM 8'h19
`define AID_OP_HI_SUM 4'h0
`define AID_OP_HI_ADC 4'h1
`define AID_OP_LO_WR_WR 4'h2
`define AID_OP_LO_WR_WRI 4'h3
`define AID_OP_LO_FR_FR 4'h4
`define AID_OP_LO_FR_FRI 4'h5
`define AID_OP_LO_FR_IMM 4'h6
`define AID_OP_LO_FRI_IMM 4'h7
`define AID_OP_LO_EXT_EXT 4'h8
`define AID_OP_LO_EXT_IMM 4'h9

// operand addressing codes
`define AID_MODE_WR 3'h0
`define AID_MODE_WR_IND 3'h1
`define AID_MODE_FR 3'h2
`define AID_MODE_FR_IND 3'h3
`define AID_MODE_IMM 3'h4
`define AID_MODE_EXT 3'h5
`define AID_MODE_NONE 3'h7

// cycle counts
`define AID_FETCH_WR 3'h2
`define AID_FETCH_FR 3'h3
`define AID_FETCH_EXT 3'h4
`define AID_EXEC_DIRECT 3'h3
`define AID_EXEC_INDIRECT 3'h4

// flag register bit positions and reset value
`define AID_FLAG_C 7
`define AID_FLAG_Z 6
`define AID_FLAG_S 5
`define AID_FLAG_V 4
`define AID_FLAG_D 3
`define AID_FLAG_H 2
`define AID_FLAGS_RESET 8'h00

`endif
